// ===== pkg/dlds_pkg.sv
package dlds_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned TICK_PERIOD_NS = 10_000_000;
  localparam int unsigned TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] TICKS_PER_TENTH_S = 4'ha;
  localparam logic [5:0] TENTHS_S_PER_TENTH_MIN = 6'h3c;
  localparam logic [7:0] FAN_STOP_TEMP_C = 8'h28;
  localparam logic [31:0] PCT_SCALE = 32'h0000_2710;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_MAXFREQ = 8'h04;
  localparam logic [7:0] REG_FWIN1 = 8'h08;
  localparam logic [7:0] REG_FWIN2 = 8'h0c;
  localparam logic [7:0] REG_LOWCUR = 8'h10;
  localparam logic [7:0] REG_OVERRUN = 8'h14;
  localparam logic [7:0] REG_CWIN1 = 8'h18;
  localparam logic [7:0] REG_CWIN2 = 8'h1c;
  localparam logic [7:0] REG_TIMEDRUN = 8'h20;
  localparam logic [7:0] REG_AGUARD = 8'h24;
  localparam logic [7:0] REG_TEMP = 8'h28;
  localparam logic [7:0] REG_WAKE = 8'h2c;
  localparam logic [7:0] REG_SLEEP = 8'h30;
  localparam logic [7:0] REG_RUNTARGET = 8'h34;
  localparam logic [7:0] REG_STATUS = 8'h38;
  localparam logic [7:0] REG_REMAIN = 8'h3c;
  localparam logic [7:0] ADDR_SPAN = 8'h40;
  localparam int CTRL_TIMED_BIT = 0;
  localparam int CTRL_FAN_BIT = 1;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values (freq 0.01 Hz, current 0.1 %, volts 0.01 V)
  localparam logic [15:0] RST_MAX_FREQ = 16'h1388;
  localparam logic [15:0] RST_FWIN_CENTER = 16'h1388;
  localparam logic [15:0] RST_FWIN_WIDTH = 16'h0000;
  localparam logic [15:0] RST_LOWCUR_LEVEL = 16'h0032;
  localparam logic [15:0] RST_LOWCUR_DELAY = 16'h000a;
  localparam logic [15:0] RST_OVR_LIMIT = 16'h07d0;
  localparam logic [15:0] RST_OVR_DELAY = 16'h0000;
  localparam logic [15:0] RST_CWIN_CENTER = 16'h03e8;
  localparam logic [15:0] RST_CWIN_WIDTH = 16'h0000;
  localparam logic [15:0] RST_TIMED_MIN = 16'h0000;
  localparam logic [15:0] RST_AGUARD_LOW = 16'h0136;
  localparam logic [15:0] RST_AGUARD_HIGH = 16'h02a8;
  localparam logic [7:0] RST_TEMP_THR = 8'h5a;
  localparam logic [15:0] RST_SLEEP_WAKE = 16'h0000;
  localparam logic [15:0] RST_RUN_TARGET = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic timedRunEnable;
    logic fanModeSelect;
    logic [15:0] maxFreq;
    logic [15:0] freqWindow1Center;
    logic [15:0] freqWindow1Width;
    logic [15:0] freqWindow2Center;
    logic [15:0] freqWindow2Width;
    logic [15:0] lowCurrentLevel;
    logic [15:0] lowCurrentDelay;
    logic [15:0] overrunCurrentLimit;
    logic [15:0] overrunCurrentDelay;
    logic [15:0] curWindow1Center;
    logic [15:0] curWindow1Width;
    logic [15:0] curWindow2Center;
    logic [15:0] curWindow2Width;
    logic [15:0] timedRunMinutes;
    logic [15:0] analogGuardLow;
    logic [15:0] analogGuardHigh;
    logic [7:0] heatsinkTempThreshold;
    logic [15:0] wakeFreq;
    logic [15:0] wakeDelay;
    logic [15:0] sleepFreq;
    logic [15:0] sleepDelay;
    logic [15:0] thisRunTimeTarget;
  } dlds_cfg_type;

  localparam dlds_cfg_type CFG_RESET = '{
    1'b0, 1'b0, RST_MAX_FREQ, RST_FWIN_CENTER, RST_FWIN_WIDTH, RST_FWIN_CENTER,
    RST_FWIN_WIDTH, RST_LOWCUR_LEVEL, RST_LOWCUR_DELAY, RST_OVR_LIMIT, RST_OVR_DELAY,
    RST_CWIN_CENTER, RST_CWIN_WIDTH, RST_CWIN_CENTER, RST_CWIN_WIDTH, RST_TIMED_MIN,
    RST_AGUARD_LOW, RST_AGUARD_HIGH, RST_TEMP_THR, RST_SLEEP_WAKE, RST_SLEEP_WAKE,
    RST_SLEEP_WAKE, RST_SLEEP_WAKE, RST_RUN_TARGET};

  typedef struct packed {
    logic [15:0] outFreq;
    logic [15:0] outCurrent;
    logic [15:0] setFreq;
    logic [15:0] analogInFirst;
    logic [7:0] heatsinkTemp;
    logic running;
    logic runCmd;
  } dlds_meas_type;

  typedef struct packed {
    logic runTimeReached;
    logic tempReached;
    logic analogOutOfRange;
    logic timedRunDone;
    logic curWindow2;
    logic curWindow1;
    logic overrunCurrent;
    logic lowCurrent;
    logic freqWindow2;
    logic freqWindow1;
  } dlds_flags_type;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } dlds_axi_req_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dlds_axi_rsp_type;

endpackage

// ===== verilog/dlds_top.sv
// Overview of operation
// RQ1 - Two frequency windows flag output frequency within center plus/minus width.
// RQ2 - Low-current flag once current stays at or below level past delay.
// RQ3 - Overrun flag once current stays above limit past delay; zero disables.
// RQ4 - Two current windows flag output current within center plus/minus width.
// RQ5 - Timed run clears timer at start; on expiry stops drive and flags.
// RQ6 - Timed run counted in tenths of minutes; remaining time readable.
// RQ7 - Analog input flag when voltage above high or below low guard.
// RQ8 - Temperature flag once heatsink reaches programmed threshold.
// RQ9 - Fan mode zero: fan on while running, or stopped above 40 degrees.
// RQ10 - Fan mode one: fan always on after power-on.
// RQ11 - Running with set frequency at or below sleep level for delay: dormant, stop.
// RQ12 - Dormant with run command, set frequency at or above wake level: restart.
// RQ13 - Sleep and wake disabled when both frequencies are zero.
// RQ14 - Software should program wake frequency no lower than sleep frequency.
// RQ15 - Software selects halted process controller while dormant.
// RQ16 - Run-time flag once time since latest start reaches target.
// RQ17 - Flags are levels re-evaluated each tick; delay counters clear on loss.
module dlds_top #(
  parameter int unsigned TICK_CYCLES = dlds_pkg::TICK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire dlds_pkg::dlds_axi_req_type axiReq,
  output dlds_pkg::dlds_axi_rsp_type axiRsp,
  input wire dlds_pkg::dlds_meas_type meas,
  output dlds_pkg::dlds_flags_type flags,
  output logic fanOn,
  output logic dormant,
  output logic driveRunEn,
  output logic [15:0] timedRunRemaining
);

  typedef struct packed {
    dlds_pkg::dlds_cfg_type cfg;
    logic [31:0] tickCnt;
    logic [3:0] tenthCnt;
    logic [5:0] minCnt;
    logic [15:0] lowCurCnt;
    logic [15:0] overCurCnt;
    logic [15:0] sleepCnt;
    logic [15:0] wakeCnt;
    logic [15:0] runElapsed;
    logic runningD;
    dlds_pkg::dlds_flags_type flags;
    logic fanOn;
    logic dormant;
    logic timedStop;
    logic driveRunEn;
    logic awHeld;
    logic [7:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dlds_state_type;

  dlds_state_type s_ff;
  dlds_state_type nxt_s;
  logic tick;
  logic tenthTick;
  logic minTick;
  logic startEdge;
  logic timedDone;
  logic sleepOn;
  logic [15:0] freqWidth1;
  logic [15:0] freqWidth2;
  logic [15:0] remain;
  logic [31:0] merged;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // 17 bits so center plus width never wraps
  function automatic logic inWindow(input logic [15:0] v, input logic [15:0] c,
                                    input logic [15:0] w);
    inWindow = ({1'b0, v} + {1'b0, w} >= {1'b0, c}) && ({1'b0, v} <= {1'b0, c} + {1'b0, w});
  endfunction

  function automatic logic [31:0] regRead(input logic [7:0] a, input dlds_state_type st,
                                          input logic [15:0] rem);
    logic [31:0] d;
    d = 32'h0000_0000;
    case ({a[7:2], 2'b00})
      dlds_pkg::REG_CTRL: begin
        d[dlds_pkg::CTRL_TIMED_BIT] = st.cfg.timedRunEnable;
        d[dlds_pkg::CTRL_FAN_BIT] = st.cfg.fanModeSelect;
      end
      dlds_pkg::REG_MAXFREQ: d = {16'h0000, st.cfg.maxFreq};
      dlds_pkg::REG_FWIN1: d = {st.cfg.freqWindow1Width, st.cfg.freqWindow1Center};
      dlds_pkg::REG_FWIN2: d = {st.cfg.freqWindow2Width, st.cfg.freqWindow2Center};
      dlds_pkg::REG_LOWCUR: d = {st.cfg.lowCurrentDelay, st.cfg.lowCurrentLevel};
      dlds_pkg::REG_OVERRUN: d = {st.cfg.overrunCurrentDelay, st.cfg.overrunCurrentLimit};
      dlds_pkg::REG_CWIN1: d = {st.cfg.curWindow1Width, st.cfg.curWindow1Center};
      dlds_pkg::REG_CWIN2: d = {st.cfg.curWindow2Width, st.cfg.curWindow2Center};
      dlds_pkg::REG_TIMEDRUN: d = {16'h0000, st.cfg.timedRunMinutes};
      dlds_pkg::REG_AGUARD: d = {st.cfg.analogGuardHigh, st.cfg.analogGuardLow};
      dlds_pkg::REG_TEMP: d = {24'h000000, st.cfg.heatsinkTempThreshold};
      dlds_pkg::REG_WAKE: d = {st.cfg.wakeDelay, st.cfg.wakeFreq};
      dlds_pkg::REG_SLEEP: d = {st.cfg.sleepDelay, st.cfg.sleepFreq};
      dlds_pkg::REG_RUNTARGET: d = {16'h0000, st.cfg.thisRunTimeTarget};
      dlds_pkg::REG_STATUS: d = {19'h00000, st.driveRunEn, st.dormant, st.fanOn, st.flags};
      dlds_pkg::REG_REMAIN: d = {16'h0000, rem};
      default: d = 32'h0000_0000;
    endcase
    regRead = d;
  endfunction

  function automatic logic [31:0] mergeStrb(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    mergeStrb = m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Time base and derived values

  assign tick = s_ff.tickCnt == 32'(TICK_CYCLES - 1);
  assign tenthTick = tick && (s_ff.tenthCnt == dlds_pkg::TICKS_PER_TENTH_S - 4'h1);
  assign minTick = tenthTick && (s_ff.minCnt == dlds_pkg::TENTHS_S_PER_TENTH_MIN - 6'h1);
  assign startEdge = meas.running && !s_ff.runningD;
  // Masked on start and while stopped, so a stop never sticks
  assign timedDone = s_ff.cfg.timedRunEnable && meas.running && !startEdge
                     && (s_ff.runElapsed >= s_ff.cfg.timedRunMinutes); // RQ5
  assign sleepOn = (s_ff.cfg.wakeFreq != 16'h0000) || (s_ff.cfg.sleepFreq != 16'h0000); // RQ13
  assign freqWidth1 = 16'((32'(s_ff.cfg.maxFreq) * 32'(s_ff.cfg.freqWindow1Width))
                          / dlds_pkg::PCT_SCALE);
  assign freqWidth2 = 16'((32'(s_ff.cfg.maxFreq) * 32'(s_ff.cfg.freqWindow2Width))
                          / dlds_pkg::PCT_SCALE);
  assign remain = (s_ff.cfg.timedRunMinutes > s_ff.runElapsed)
                  ? s_ff.cfg.timedRunMinutes - s_ff.runElapsed : 16'h0000; // RQ6
  assign merged = mergeStrb(regRead(s_ff.awAddr, s_ff, remain), s_ff.wData, s_ff.wStrb);

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    nxt_s = s_ff;
    nxt_s.tickCnt = tick ? 32'h0000_0000 : s_ff.tickCnt + 32'h0000_0001;
    if (tick) begin
      nxt_s.tenthCnt = tenthTick ? 4'h0 : s_ff.tenthCnt + 4'h1;
    end
    if (startEdge) begin
      nxt_s.minCnt = 6'h00;
    end else if (tenthTick) begin
      nxt_s.minCnt = minTick ? 6'h00 : s_ff.minCnt + 6'h01;
    end
    nxt_s.runningD = meas.running;

    // Run time since start, 0.1 min
    if (startEdge) begin
      nxt_s.runElapsed = 16'h0000; // RQ5
    end else if (meas.running && minTick && s_ff.runElapsed != 16'hffff) begin
      nxt_s.runElapsed = s_ff.runElapsed + 16'h0001; // RQ6
    end

    // Expiry wins over release
    if (timedDone) begin
      nxt_s.timedStop = 1'b1; // RQ5
    end else if (!meas.runCmd) begin
      nxt_s.timedStop = 1'b0;
    end
    nxt_s.flags.timedRunDone = timedDone; // RQ5

    if (tick) begin
      nxt_s.flags.freqWindow1 = inWindow(meas.outFreq, s_ff.cfg.freqWindow1Center,
                                         freqWidth1); // RQ1
      nxt_s.flags.freqWindow2 = inWindow(meas.outFreq, s_ff.cfg.freqWindow2Center,
                                         freqWidth2); // RQ1
      nxt_s.flags.curWindow1 = inWindow(meas.outCurrent, s_ff.cfg.curWindow1Center,
                                        s_ff.cfg.curWindow1Width); // RQ4
      nxt_s.flags.curWindow2 = inWindow(meas.outCurrent, s_ff.cfg.curWindow2Center,
                                        s_ff.cfg.curWindow2Width); // RQ4
      if (meas.outCurrent <= s_ff.cfg.lowCurrentLevel) begin
        if (s_ff.lowCurCnt < s_ff.cfg.lowCurrentDelay) begin
          nxt_s.lowCurCnt = s_ff.lowCurCnt + 16'h0001;
        end
        nxt_s.flags.lowCurrent = s_ff.lowCurCnt >= s_ff.cfg.lowCurrentDelay; // RQ2
      end else begin
        nxt_s.lowCurCnt = 16'h0000; // RQ17
        nxt_s.flags.lowCurrent = 1'b0;
      end
      if (s_ff.cfg.overrunCurrentLimit != 16'h0000
          && meas.outCurrent > s_ff.cfg.overrunCurrentLimit) begin
        if (s_ff.overCurCnt < s_ff.cfg.overrunCurrentDelay) begin
          nxt_s.overCurCnt = s_ff.overCurCnt + 16'h0001;
        end
        nxt_s.flags.overrunCurrent = s_ff.overCurCnt >= s_ff.cfg.overrunCurrentDelay; // RQ3
      end else begin
        nxt_s.overCurCnt = 16'h0000; // RQ17
        nxt_s.flags.overrunCurrent = 1'b0;
      end
      nxt_s.flags.analogOutOfRange = (meas.analogInFirst > s_ff.cfg.analogGuardHigh)
                                     || (meas.analogInFirst < s_ff.cfg.analogGuardLow); // RQ7
      nxt_s.flags.tempReached = meas.heatsinkTemp >= s_ff.cfg.heatsinkTempThreshold; // RQ8
      nxt_s.flags.runTimeReached = meas.running && s_ff.cfg.thisRunTimeTarget != 16'h0000
                                   && s_ff.runElapsed >= s_ff.cfg.thisRunTimeTarget; // RQ16
    end

    if (s_ff.cfg.fanModeSelect) begin
      nxt_s.fanOn = 1'b1; // RQ10
    end else begin
      nxt_s.fanOn = meas.running || (meas.heatsinkTemp > dlds_pkg::FAN_STOP_TEMP_C); // RQ9
    end

    // Sleep and wake on the 0.1 s tick
    if (!sleepOn) begin
      nxt_s.dormant = 1'b0; // RQ13
      nxt_s.sleepCnt = 16'h0000;
      nxt_s.wakeCnt = 16'h0000;
    end else if (!s_ff.dormant) begin
      nxt_s.wakeCnt = 16'h0000;
      if (meas.running && meas.setFreq <= s_ff.cfg.sleepFreq) begin
        if (tenthTick) begin
          if (s_ff.sleepCnt >= s_ff.cfg.sleepDelay) begin
            nxt_s.dormant = 1'b1; // RQ11
            nxt_s.sleepCnt = 16'h0000;
          end else begin
            nxt_s.sleepCnt = s_ff.sleepCnt + 16'h0001;
          end
        end
      end else begin
        nxt_s.sleepCnt = 16'h0000;
      end
    end else begin
      nxt_s.sleepCnt = 16'h0000;
      if (!meas.runCmd) begin
        // No command: nothing to wake for
        nxt_s.dormant = 1'b0;
        nxt_s.wakeCnt = 16'h0000;
      end else if (meas.setFreq >= s_ff.cfg.wakeFreq) begin
        if (tenthTick) begin
          if (s_ff.wakeCnt >= s_ff.cfg.wakeDelay) begin
            nxt_s.dormant = 1'b0; // RQ12
            nxt_s.wakeCnt = 16'h0000;
          end else begin
            nxt_s.wakeCnt = s_ff.wakeCnt + 16'h0001;
          end
        end
      end else begin
        nxt_s.wakeCnt = 16'h0000;
      end
    end
    nxt_s.driveRunEn = meas.runCmd && !nxt_s.timedStop && !nxt_s.dormant; // RQ5 RQ11 RQ12

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write, aw and w in either order
    if (axiReq.awvalid && axiRsp.awready) begin
      nxt_s.awHeld = 1'b1;
      nxt_s.awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && axiRsp.wready) begin
      nxt_s.wHeld = 1'b1;
      nxt_s.wData = axiReq.wdata;
      nxt_s.wStrb = axiReq.wstrb;
    end
    if (s_ff.awHeld && s_ff.wHeld) begin
      nxt_s.awHeld = 1'b0;
      nxt_s.wHeld = 1'b0;
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp = (s_ff.awAddr >= dlds_pkg::ADDR_SPAN) ? dlds_pkg::AXI_SLVERR
                                                        : dlds_pkg::AXI_OKAY;
      case ({s_ff.awAddr[7:2], 2'b00})
        dlds_pkg::REG_CTRL: begin
          nxt_s.cfg.timedRunEnable = merged[dlds_pkg::CTRL_TIMED_BIT];
          nxt_s.cfg.fanModeSelect = merged[dlds_pkg::CTRL_FAN_BIT];
        end
        dlds_pkg::REG_MAXFREQ: nxt_s.cfg.maxFreq = merged[15:0];
        dlds_pkg::REG_FWIN1: {nxt_s.cfg.freqWindow1Width, nxt_s.cfg.freqWindow1Center} = merged;
        dlds_pkg::REG_FWIN2: {nxt_s.cfg.freqWindow2Width, nxt_s.cfg.freqWindow2Center} = merged;
        dlds_pkg::REG_LOWCUR: {nxt_s.cfg.lowCurrentDelay, nxt_s.cfg.lowCurrentLevel} = merged;
        dlds_pkg::REG_OVERRUN: begin
          {nxt_s.cfg.overrunCurrentDelay, nxt_s.cfg.overrunCurrentLimit} = merged;
        end
        dlds_pkg::REG_CWIN1: {nxt_s.cfg.curWindow1Width, nxt_s.cfg.curWindow1Center} = merged;
        dlds_pkg::REG_CWIN2: {nxt_s.cfg.curWindow2Width, nxt_s.cfg.curWindow2Center} = merged;
        dlds_pkg::REG_TIMEDRUN: nxt_s.cfg.timedRunMinutes = merged[15:0];
        dlds_pkg::REG_AGUARD: {nxt_s.cfg.analogGuardHigh, nxt_s.cfg.analogGuardLow} = merged;
        dlds_pkg::REG_TEMP: nxt_s.cfg.heatsinkTempThreshold = merged[7:0];
        dlds_pkg::REG_WAKE: {nxt_s.cfg.wakeDelay, nxt_s.cfg.wakeFreq} = merged;
        dlds_pkg::REG_SLEEP: {nxt_s.cfg.sleepDelay, nxt_s.cfg.sleepFreq} = merged;
        dlds_pkg::REG_RUNTARGET: nxt_s.cfg.thisRunTimeTarget = merged[15:0];
        default: nxt_s.cfg = s_ff.cfg;
      endcase
    end
    if (s_ff.bvalid && axiReq.bready) begin
      nxt_s.bvalid = 1'b0;
    end

    // Read: answered one cycle after the address
    if (s_ff.rvalid && axiReq.rready) begin
      nxt_s.rvalid = 1'b0;
    end
    if (axiReq.arvalid && axiRsp.arready) begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rdata = regRead(axiReq.araddr, s_ff, remain);
      nxt_s.rresp = (axiReq.araddr >= dlds_pkg::ADDR_SPAN) ? dlds_pkg::AXI_SLVERR
                                                           : dlds_pkg::AXI_OKAY;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_ff <= '0;
      s_ff.cfg <= dlds_pkg::CFG_RESET;
    end else begin
      s_ff <= nxt_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign axiRsp.awready = !s_ff.awHeld && !s_ff.bvalid;
  assign axiRsp.wready = !s_ff.wHeld && !s_ff.bvalid;
  assign axiRsp.bvalid = s_ff.bvalid;
  assign axiRsp.bresp = s_ff.bresp;
  assign axiRsp.arready = !s_ff.rvalid;
  assign axiRsp.rvalid = s_ff.rvalid;
  assign axiRsp.rdata = s_ff.rdata;
  assign axiRsp.rresp = s_ff.rresp;
  assign flags = s_ff.flags;
  assign fanOn = s_ff.fanOn;
  assign dormant = s_ff.dormant;
  assign driveRunEn = s_ff.driveRunEn;
  assign timedRunRemaining = remain;

endmodule

// ===== verification/dlds_flag_reader.sv
module dlds_flag_reader (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire dlds_pkg::dlds_flags_type flags,
  output logic [7:0] doneCount
);
  timeunit 1ns;
  timeprecision 100ps;
  logic lastDone;
  // Host counts stop events by edge
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      lastDone <= 1'b0;
      doneCount <= 8'h00;
    end else begin
      lastDone <= flags.timedRunDone;
      doneCount <= doneCount + 8'(flags.timedRunDone && !lastDone);
    end
  end
endmodule

// ===== verification/dlds_top_sva.sv
module dlds_top_sva (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire dlds_pkg::dlds_axi_req_type axiReq,
  input wire dlds_pkg::dlds_axi_rsp_type axiRsp,
  input wire dlds_pkg::dlds_meas_type meas,
  input wire dlds_pkg::dlds_flags_type flags,
  input wire logic fanOn,
  input wire logic dormant,
  input wire logic driveRunEn,
  input wire logic [15:0] timedRunRemaining
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  sequence wrTaken;
    axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready;
  endsequence
  sequence rdTaken;
    axiReq.arvalid && axiRsp.arready;
  endsequence
  wr_answer_a: assert property (wrTaken |-> ##[1:3] axiRsp.bvalid)
    else $error("no bvalid");
  wr_busy_a: assert property (wrTaken |=> !axiRsp.awready && !axiRsp.wready)
    else $error("aw or w open");
  rd_answer_a: assert property (rdTaken |=> axiRsp.rvalid)
    else $error("no rvalid");
  rdata_hold_a: assert property (axiRsp.rvalid && !axiReq.rready |=> $stable(axiRsp.rdata))
    else $error("rdata moved");
  rd_unmapped_a: assert property (rdTaken ##0 axiReq.araddr >= dlds_pkg::ADDR_SPAN
    |=> axiRsp.rresp == dlds_pkg::AXI_SLVERR && axiRsp.rdata == 32'h0)
    else $error("bad read ok");
  fan_needed_a: assert property ((meas.running || meas.heatsinkTemp > 8'h28)[*3] |-> fanOn)
    else $error("fan off");
  run_gate_a: assert property (!meas.runCmd |=> !driveRunEn)
    else $error("run without cmd");
  sleep_stop_a: assert property (dormant[*2] |-> !driveRunEn)
    else $error("run while dormant");
  timed_stop_a: assert property (flags.timedRunDone[*2] |-> !driveRunEn)
    else $error("run after stop");
  remain_zero_a: assert property (flags.timedRunDone[*2] |-> timedRunRemaining == 16'h0)
    else $error("time left");
endmodule

bind dlds_top dlds_top_sva sva (.clk_sys(clk_sys), .nrst(nrst),
  .axiReq(axiReq), .axiRsp(axiRsp), .meas(meas), .flags(flags), .fanOn(fanOn),
  .dormant(dormant), .driveRunEn(driveRunEn), .timedRunRemaining(timedRunRemaining));

// ===== verification/dlds_top_tb.sv
module dlds_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TK = 20;
  logic clk_sys;
  logic nrst;
  dlds_pkg::dlds_axi_req_type axiReq;
  dlds_pkg::dlds_axi_rsp_type axiRsp;
  dlds_pkg::dlds_meas_type meas;
  dlds_pkg::dlds_flags_type flags;
  logic fanOn;
  logic dormant;
  logic driveRunEn;
  logic [15:0] timedRunRemaining;
  logic [7:0] doneCount;
  logic [31:0] rd;
  logic [1:0] rs;
  int errors;
  int num_checks;

  dlds_top #(.TICK_CYCLES(TK)) dut (.clk_sys(clk_sys), .nrst(nrst), .axiReq(axiReq),
    .axiRsp(axiRsp), .meas(meas), .flags(flags), .fanOn(fanOn), .dormant(dormant),
    .driveRunEn(driveRunEn), .timedRunRemaining(timedRunRemaining));
  dlds_flag_reader host (.clk_sys(clk_sys), .nrst(nrst), .flags(flags), .doneCount(doneCount));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  ////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Flags land one edge after a tick
  task automatic wt(input int n);
    repeat (n * TK + 2) @(posedge clk_sys);
  endtask
  task automatic run(input logic v);
    meas.runCmd <= v;
    meas.running <= v;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr <= a;
    axiReq.wvalid <= 1'b1;
    axiReq.wdata <= d;
    axiReq.wstrb <= 4'hf;
    axiReq.bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (axiRsp.awready) axiReq.awvalid <= 1'b0;
      if (axiRsp.wready) axiReq.wvalid <= 1'b0;
    end while (axiRsp.bvalid !== 1'b1);
    rs = axiRsp.bresp;
    axiReq.bready <= 1'b0;
  endtask
  // Late ready tests a held response
  task automatic axi_rd(input logic [7:0] a);
    @(posedge clk_sys);
    axiReq.arvalid <= 1'b1;
    axiReq.araddr <= a;
    do begin
      @(posedge clk_sys);
      if (axiRsp.arready) axiReq.arvalid <= 1'b0;
      if (axiRsp.rvalid) axiReq.rready <= 1'b1;
    end while (!(axiRsp.rvalid === 1'b1 && axiReq.rready));
    rd = axiRsp.rdata;
    rs = axiRsp.rresp;
    axiReq.rready <= 1'b0;
  endtask

  ////////////////////
  task automatic t_regs();
    axi_rd(dlds_pkg::REG_LOWCUR);
    chk(rd, {dlds_pkg::RST_LOWCUR_DELAY, dlds_pkg::RST_LOWCUR_LEVEL}, "lowcur");
    axi_rd(dlds_pkg::REG_AGUARD);
    chk(rd, {dlds_pkg::RST_AGUARD_HIGH, dlds_pkg::RST_AGUARD_LOW}, "guard");
    axi_rd(dlds_pkg::REG_TEMP);
    chk(rd, 32'(dlds_pkg::RST_TEMP_THR), "temp");
    axi_rd(8'h40);
    chk({rd[29:0], rs}, 32'(dlds_pkg::AXI_SLVERR), "rd map");
    axi_wr(8'h44, 32'hffff_ffff);
    chk(32'(rs), 32'(dlds_pkg::AXI_SLVERR), "wr map");
    axi_wr(dlds_pkg::REG_REMAIN, 32'h5);
    axi_rd(dlds_pkg::REG_REMAIN);
    chk({rd[29:0], rs}, 32'h0, "remain");
    $display("regs done");
  endtask
  task automatic t_win();
    axi_wr(dlds_pkg::REG_FWIN1, 32'h03e8_1388);
    axi_wr(dlds_pkg::REG_CWIN1, 32'h0064_03e8);
    meas.outFreq <= 16'h1577;
    meas.outCurrent <= 16'h0440;
    wt(2);
    chk(32'(flags[3:2]), 32'h0, "lo");
    chk(32'({flags.curWindow2, flags.curWindow1, flags[1:0]}), 32'h5, "win in");
    meas.outFreq <= 16'h1588;
    meas.outCurrent <= 16'h0350;
    wt(2);
    chk(32'({flags.curWindow1, flags.freqWindow1}), 32'h0, "win out");
    $display("windows done");
  endtask
  task automatic t_cur();
    axi_wr(dlds_pkg::REG_LOWCUR, 32'h0002_0032);
    axi_wr(dlds_pkg::REG_OVERRUN, 32'h0);
    meas.outCurrent <= 16'h0032;
    wt(1);
    chk(32'(flags.lowCurrent), 32'h0, "low early");
    wt(3);
    chk(32'(flags.lowCurrent), 32'h1, "low set");
    meas.outCurrent <= 16'h0fff;
    wt(3);
    chk(32'({flags.overrunCurrent, flags.lowCurrent}), 32'h0, "ovr off");
    axi_wr(dlds_pkg::REG_OVERRUN, 32'h0001_07d0);
    meas.outCurrent <= 16'h07d0;
    wt(3);
    chk(32'(flags.overrunCurrent), 32'h0, "ovr edge");
    meas.outCurrent <= 16'h07d1;
    wt(3);
    chk(32'(flags.overrunCurrent), 32'h1, "ovr set");
    $display("current done");
  endtask
  task automatic t_env();
    logic [15:0] av[4] = '{16'h0135, 16'h0136, 16'h02a8, 16'h02a9};
    logic [7:0] tv[4] = '{8'h28, 8'h29, 8'h59, 8'h5a};
    for (int i = 0; i < 4; i++) begin
      meas.analogInFirst <= av[i];
      meas.heatsinkTemp <= tv[i];
      wt(1);
      chk(32'(flags.analogOutOfRange), 32'(i % 3 == 0), "analog");
      chk(32'(fanOn), 32'(i > 0), "fan");
      chk(32'(flags.tempReached), 32'(i == 3), "temp");
    end
    meas.heatsinkTemp <= 8'h10;
    meas.running <= 1'b1;
    wt(1);
    chk(32'(fanOn), 32'h1, "fan run");
    meas.running <= 1'b0;
    wt(1);
    chk(32'(fanOn), 32'h0, "fan stop");
    axi_wr(dlds_pkg::REG_CTRL, 32'h2);
    wt(1);
    chk(32'(fanOn), 32'h1, "fan mode");
    $display("env done");
  endtask
  task automatic t_timed();
    int n;
    axi_wr(dlds_pkg::REG_TIMEDRUN, 32'h2);
    axi_wr(dlds_pkg::REG_RUNTARGET, 32'h1);
    axi_wr(dlds_pkg::REG_CTRL, 32'h1);
    run(1'b1);
    wt(1);
    chk(32'({driveRunEn, timedRunRemaining}), 32'h1_0002, "start");
    for (n = 0; n < 25000 && flags.timedRunDone !== 1'b1; n++)
      @(posedge clk_sys);
    chk(32'(n > 11900), 32'h1, "duration");
    repeat (2) @(posedge clk_sys);
    chk(32'({flags.runTimeReached, flags.timedRunDone, driveRunEn}), 32'h6, "expiry");
    chk(32'({doneCount, timedRunRemaining}), 32'h1_0000, "remain");
    run(1'b0);
    wt(1);
    run(1'b1);
    wt(1);
    chk(32'({driveRunEn, flags[9], flags[6], timedRunRemaining}), 32'h4_0002, "rerun");
    run(1'b0);
    axi_wr(dlds_pkg::REG_CTRL, 32'h0);
    $display("timed done");
  endtask
  task automatic t_sleep();
    run(1'b1);
    wt(25);
    chk(32'({dormant, driveRunEn}), 32'h1, "no sleep");
    meas.setFreq <= 16'h0150;
    axi_wr(dlds_pkg::REG_WAKE, 32'h0001_0200);
    axi_wr(dlds_pkg::REG_SLEEP, 32'h0001_0100);
    meas.setFreq <= 16'h0100;
    wt(5);
    chk(32'(dormant), 32'h0, "sleep wait");
    wt(30);
    chk(32'({dormant, driveRunEn}), 32'h2, "asleep");
    meas.running <= 1'b0;
    meas.setFreq <= 16'h01ff;
    wt(30);
    chk(32'(dormant), 32'h1, "low set");
    meas.setFreq <= 16'h0200;
    wt(5);
    chk(32'(dormant), 32'h1, "wake wait");
    wt(30);
    chk(32'({dormant, driveRunEn}), 32'h1, "awake");
    run(1'b0);
    $display("sleep done");
  endtask

  ////////////////////
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    errors = 0;
    num_checks = 0;
    axiReq = '0;
    meas = '0;
    nrst = 1'b0;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    t_regs();
    t_win();
    t_cur();
    t_env();
    t_timed();
    t_sleep();
    test_done();
  end
  // About twice the expected run
  initial begin
    #1500000;
    errors++;
    test_done();
  end
endmodule
